// >>> shared/epc_pkg.sv
package epc_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int EPC_NUM_Q    = 4;
  localparam int EPC_Q_DEPTH  = 4;
  localparam int EPC_MAC_ENT  = 4;
  localparam int EPC_IP_ENT   = 4;
  localparam int EPC_LEN_W    = 16;
  localparam int EPC_ID_W     = 8;
  localparam int EPC_LOAD_W   = 21;
  localparam int EPC_ADDR_W   = 8;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] EPC_CTRL_OFS     = 8'h00;
  localparam logic [7:0] EPC_THRESH_OFS   = 8'h04;
  localparam logic [7:0] EPC_STATUS_OFS   = 8'h08;
  localparam logic [7:0] EPC_IRQ_STAT_OFS = 8'h0C;
  localparam logic [7:0] EPC_IRQ_CLR_OFS  = 8'h10;
  localparam logic [7:0] EPC_IRQ_EN_OFS   = 8'h14;
  localparam logic [7:0] EPC_MAC_BASE     = 8'h40;
  localparam logic [7:0] EPC_IP_BASE      = 8'h80;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EPC_CTRL_FC_EN_BIT = 0;
  localparam int EPC_ENT_VLD_BIT    = 31;
  localparam int EPC_ENT_DIR_LSB    = 28;
  localparam int EPC_ENT_PRIO_LSB   = 24;
  localparam int EPC_EVT_DROP_BIT   = 0;
  localparam int EPC_EVT_FC_BIT     = 1;
  localparam int EPC_ST_DROP_BIT    = 0;
  localparam int EPC_ST_FC_BIT      = 1;
  localparam int EPC_ST_QNE_LSB     = 4;

  // ----------------------------------------------------------------
  // reset and default values
  // ----------------------------------------------------------------
  localparam logic [15:0] EPC_THRESH_RST = 16'hE000;
  localparam logic [2:0]  EPC_PRIO_DFLT  = 3'h0;

  typedef enum logic [1:0] {
    EPC_DIR_DST,
    EPC_DIR_SRC,
    EPC_DIR_EITHER
  } epc_dir_e;

endpackage

// >>> rtl/epc_queue.sv
`timescale 1ns/1ps
module epc_queue
  import epc_pkg::*;
#(
  parameter int WIDTH = EPC_LEN_W + EPC_ID_W
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head,
  output logic                  full,
  output logic                  empty
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem_r [EPC_Q_DEPTH];
  logic [1:0]       wr_ptr_r;
  logic [1:0]       rd_ptr_r;
  logic [2:0]       cnt_r;
  logic             do_push;
  logic             do_pop;

  // push while full is ignored; the caller treats that as a drop
  assign do_push = push && (cnt_r != 3'(EPC_Q_DEPTH));
  assign do_pop  = pop && (cnt_r != 3'h0);
  assign full    = (cnt_r == 3'(EPC_Q_DEPTH));
  assign empty   = (cnt_r == 3'h0);
  assign head    = mem_r[rd_ptr_r];

  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem_r[wr_ptr_r] <= wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= 2'h0;
      rd_ptr_r <= 2'h0;
      cnt_r    <= 3'h0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + 2'h1;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + 2'h1;
      end
      cnt_r <= cnt_r + 3'(do_push) - 3'(do_pop);
    end
  end

endmodule // epc_queue

// >>> rtl/epc_top.sv
`timescale 1ns/1ps
module epc_top
  import epc_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire logic [EPC_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_we,
  input  wire logic                  reg_re,
  output logic      [31:0]           reg_rdata,
  input  wire logic                  frm_valid,
  input  wire logic [EPC_ID_W-1:0]   frm_id,
  input  wire logic [EPC_LEN_W-1:0]  frm_len,
  input  wire logic [11:0]           frm_vlan,
  input  wire logic [47:0]           frm_dmac,
  input  wire logic [47:0]           frm_smac,
  input  wire logic                  frm_is_ip,
  input  wire logic [31:0]           frm_dip,
  input  wire logic [31:0]           frm_sip,
  input  wire logic                  tx_ready,
  output logic                       tx_valid,
  output logic      [1:0]            tx_queue,
  output logic      [EPC_ID_W-1:0]   tx_id,
  output logic      [EPC_LEN_W-1:0]  tx_len,
  output logic                       fc_active,
  output logic                       drop_active,
  output logic                       irq
);

  localparam int QW = EPC_LEN_W + EPC_ID_W;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_q1_r;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_q1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_n    <= rst_q1_r;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic dir_hit(input logic [1:0] dir, input logic dhit, input logic shit);
    case (dir)
      EPC_DIR_DST:    dir_hit = dhit;
      EPC_DIR_SRC:    dir_hit = shit;
      EPC_DIR_EITHER: dir_hit = dhit | shit;
      default:        dir_hit = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [31:0] mac_lo_r  [EPC_MAC_ENT];
  logic [31:0] mac_cfg_r [EPC_MAC_ENT];
  logic [11:0] mac_vlan_r[EPC_MAC_ENT];
  logic [31:0] ip_addr_r [EPC_IP_ENT];
  logic [31:0] ip_cfg_r  [EPC_IP_ENT];
  logic        fc_en_r;
  logic [15:0] thresh_r;
  logic [1:0]  irq_stat_r;
  logic [1:0]  irq_en_r;
  logic [1:0]  evt;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fc_en_r  <= 1'b0;
      thresh_r <= EPC_THRESH_RST;
      irq_en_r <= 2'h0;
      for (int i = 0; i < EPC_MAC_ENT; i++) begin
        mac_lo_r[i]   <= 32'h0;
        mac_cfg_r[i]  <= 32'h0;
        mac_vlan_r[i] <= 12'h0;
      end
      for (int i = 0; i < EPC_IP_ENT; i++) begin
        ip_addr_r[i] <= 32'h0;
        ip_cfg_r[i]  <= 32'h0;
      end
    end else if (reg_we) begin
      case (reg_addr)
        EPC_CTRL_OFS:   fc_en_r  <= reg_wdata[EPC_CTRL_FC_EN_BIT];
        EPC_THRESH_OFS: thresh_r <= reg_wdata[15:0];
        EPC_IRQ_EN_OFS: irq_en_r <= reg_wdata[1:0];
        default: ;
      endcase
      for (int i = 0; i < EPC_MAC_ENT; i++) begin
        if (reg_addr == EPC_MAC_BASE + 8'(i * 16)) begin
          mac_lo_r[i] <= reg_wdata;
        end
        if (reg_addr == EPC_MAC_BASE + 8'(i * 16 + 4)) begin
          mac_cfg_r[i] <= reg_wdata;
        end
        if (reg_addr == EPC_MAC_BASE + 8'(i * 16 + 8)) begin
          mac_vlan_r[i] <= reg_wdata[11:0];
        end
      end
      for (int i = 0; i < EPC_IP_ENT; i++) begin
        if (reg_addr == EPC_IP_BASE + 8'(i * 8)) begin
          ip_addr_r[i] <= reg_wdata;
        end
        if (reg_addr == EPC_IP_BASE + 8'(i * 8 + 4)) begin
          ip_cfg_r[i] <= reg_wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // classification
  // ----------------------------------------------------------------
  logic [2:0] cls_prio;
  logic       cls_drop;

  always_comb begin
    logic dh;
    logic sh;
    dh       = 1'b0;
    sh       = 1'b0;
    cls_prio = EPC_PRIO_DFLT;
    cls_drop = 1'b0;
    // walk downward so the lowest matching entry wins
    for (int i = EPC_MAC_ENT - 1; i >= 0; i--) begin
      dh = (frm_dmac == {mac_cfg_r[i][15:0], mac_lo_r[i]});
      sh = (frm_smac == {mac_cfg_r[i][15:0], mac_lo_r[i]});
      if (mac_cfg_r[i][EPC_ENT_VLD_BIT] && (frm_vlan == mac_vlan_r[i])
          && dir_hit(mac_cfg_r[i][EPC_ENT_DIR_LSB +: 2], dh, sh)) begin
        cls_prio = mac_cfg_r[i][EPC_ENT_PRIO_LSB +: 3];
      end
    end
    for (int i = 0; i < EPC_IP_ENT; i++) begin
      dh = (frm_dip == ip_addr_r[i]);
      sh = (frm_sip == ip_addr_r[i]);
      if (frm_is_ip && ip_cfg_r[i][EPC_ENT_VLD_BIT]
          && dir_hit(ip_cfg_r[i][EPC_ENT_DIR_LSB +: 2], dh, sh)) begin
        cls_drop = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // enqueue stage
  // ----------------------------------------------------------------
  logic          stg_vld_r;
  logic          stg_drop_r;
  logic [1:0]    stg_q_r;
  logic [QW-1:0] stg_data_r;
  logic [3:0]    q_full;
  logic [3:0]    q_empty;
  logic [3:0]    q_push;
  logic [3:0]    q_pop;
  logic [QW-1:0] q_head [EPC_NUM_Q];
  logic          push_ok;
  logic          push_drop;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stg_vld_r  <= 1'b0;
      stg_drop_r <= 1'b0;
      stg_q_r    <= 2'h0;
      stg_data_r <= '0;
    end else begin
      stg_vld_r  <= frm_valid;
      stg_drop_r <= cls_drop;
      stg_q_r    <= cls_prio[2:1];
      stg_data_r <= {frm_len, frm_id};
    end
  end

  // a full target queue tail-drops the frame
  assign push_drop = stg_vld_r && (stg_drop_r || q_full[stg_q_r]);
  assign push_ok   = stg_vld_r && !push_drop;

  always_comb begin
    q_push = 4'h0;
    if (push_ok) begin
      q_push[stg_q_r] = 1'b1;
    end
  end

  for (genvar g = 0; g < EPC_NUM_Q; g++) begin : g_q
    epc_queue #(
      .WIDTH (QW)
    ) u_queue (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .push    (q_push[g]),
      .wdata   (stg_data_r),
      .pop     (q_pop[g]),
      .head    (q_head[g]),
      .full    (q_full[g]),
      .empty   (q_empty[g])
    );
  end

  // ----------------------------------------------------------------
  // strict priority scheduler
  // ----------------------------------------------------------------
  logic       adv;
  logic       sel_vld;
  logic [1:0] sel_q;

  assign adv = !tx_valid || tx_ready;

  always_comb begin
    sel_vld = 1'b0;
    sel_q   = 2'h0;
    q_pop   = 4'h0;
    for (int i = 0; i < EPC_NUM_Q; i++) begin
      if (!q_empty[i]) begin
        sel_vld = 1'b1;
        sel_q   = 2'(i);
      end
    end
    if (adv && sel_vld) begin
      q_pop[sel_q] = 1'b1;
    end
  end

  // one frame waits in the output slot, so a higher frame arriving
  // behind it is passed over once; this is the permitted slack
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid <= 1'b0;
      tx_queue <= 2'h0;
      tx_id    <= '0;
      tx_len   <= '0;
    end else if (adv) begin
      tx_valid <= sel_vld;
      if (sel_vld) begin
        tx_queue <= sel_q;
        {tx_len, tx_id} <= q_head[sel_q];
      end
    end
  end

  // ----------------------------------------------------------------
  // load and flow control
  // ----------------------------------------------------------------
  logic [EPC_LOAD_W-1:0] load_r;
  logic [EPC_LOAD_W-1:0] add_len;
  logic [EPC_LOAD_W-1:0] sub_len;
  logic                  fc_nxt;

  assign add_len = push_ok ? EPC_LOAD_W'(stg_data_r[QW-1:EPC_ID_W]) : '0;
  assign sub_len = (adv && sel_vld) ? EPC_LOAD_W'(q_head[sel_q][QW-1:EPC_ID_W]) : '0;
  assign fc_nxt  = fc_en_r && (load_r >= EPC_LOAD_W'(thresh_r));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_r <= '0;
    end else begin
      load_r <= load_r + add_len - sub_len;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fc_active <= 1'b0;
    end else begin
      fc_active <= fc_nxt;
    end
  end

  // drop status stays up from a dropped frame to the next accepted one
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      drop_active <= 1'b0;
    end else if (push_drop) begin
      drop_active <= 1'b1;
    end else if (push_ok) begin
      drop_active <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign evt[EPC_EVT_DROP_BIT] = push_drop;
  assign evt[EPC_EVT_FC_BIT]   = fc_nxt && !fc_active;

  // set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= 2'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((reg_we && reg_addr == EPC_IRQ_CLR_OFS) ? reg_wdata[1:0] : 2'h0)) | evt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_en_r);
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  logic [31:0] rd_val;

  always_comb begin
    rd_val = 32'h0;
    case (reg_addr)
      EPC_CTRL_OFS:     rd_val[EPC_CTRL_FC_EN_BIT] = fc_en_r;
      EPC_THRESH_OFS:   rd_val[15:0] = thresh_r;
      EPC_STATUS_OFS: begin
        rd_val[EPC_ST_DROP_BIT] = drop_active;
        rd_val[EPC_ST_FC_BIT]   = fc_active;
        rd_val[EPC_ST_QNE_LSB +: 4] = ~q_empty;
      end
      EPC_IRQ_STAT_OFS: rd_val[1:0] = irq_stat_r;
      EPC_IRQ_EN_OFS:   rd_val[1:0] = irq_en_r;
      default: ;
    endcase
    for (int i = 0; i < EPC_MAC_ENT; i++) begin
      if (reg_addr == EPC_MAC_BASE + 8'(i * 16)) begin
        rd_val = mac_lo_r[i];
      end
      if (reg_addr == EPC_MAC_BASE + 8'(i * 16 + 4)) begin
        rd_val = mac_cfg_r[i];
      end
      if (reg_addr == EPC_MAC_BASE + 8'(i * 16 + 8)) begin
        rd_val = {20'h0, mac_vlan_r[i]};
      end
    end
    for (int i = 0; i < EPC_IP_ENT; i++) begin
      if (reg_addr == EPC_IP_BASE + 8'(i * 8)) begin
        rd_val = ip_addr_r[i];
      end
      if (reg_addr == EPC_IP_BASE + 8'(i * 8 + 4)) begin
        rd_val = ip_cfg_r[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_re) begin
      reg_rdata <= rd_val;
    end else begin
      reg_rdata <= 32'h0;
    end
  end

endmodule // epc_top

// >>> dv/epc_monitor.sv
`timescale 1ns/1ps
module epc_monitor
  import epc_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  rstn,
  input wire logic [EPC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0]           reg_wdata,
  input wire logic                  reg_we,
  input wire logic                  reg_re,
  input wire logic [31:0]           reg_rdata,
  input wire logic                  frm_valid,
  input wire logic                  tx_ready,
  input wire logic                  tx_valid,
  input wire logic [1:0]            tx_queue,
  input wire logic [EPC_ID_W-1:0]   tx_id,
  input wire logic                  fc_active,
  input wire logic                  drop_active,
  input wire logic                  irq
);
  // ----------------------------------------
  // port checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic fc_en_r;
  // shadow of the enable bit; only bus writes can move it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) fc_en_r <= 1'b0;
    else if (reg_we && reg_addr == EPC_CTRL_OFS) fc_en_r <= reg_wdata[EPC_CTRL_FC_EN_BIT];
  end
  property p_rd_idle; !$past(reg_re) |-> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data set outside read");
  property p_status;
    reg_re && reg_addr == EPC_STATUS_OFS |=> reg_rdata[EPC_ST_DROP_BIT] == $past(drop_active)
      && reg_rdata[EPC_ST_FC_BIT] == $past(fc_active);
  endproperty
  a_status: assert property (p_status) else $error("status bits differ from outputs");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_queue) && $stable(tx_id); endproperty
  a_hold: assert property (p_hold) else $error("tx slot changed while stalled");
  property p_fc_rise; $rose(fc_active) |-> fc_en_r; endproperty
  a_fc_rise: assert property (p_fc_rise) else $error("flow control while disabled");
  property p_fc_off; $fell(fc_en_r) |-> ##[0:2] !fc_active; endproperty
  a_fc_off: assert property (p_fc_off) else $error("flow control kept after disable");
  property p_irq_fall; $fell(irq) |-> $past(reg_we) || $past(reg_we, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
  property p_drop_rise; $rose(drop_active) |-> $past(frm_valid) || $past(frm_valid, 2) || $past(frm_valid, 3); endproperty
  a_drop_rise: assert property (p_drop_rise) else $error("drop without a frame");
  property p_en_off; reg_we && reg_addr == EPC_IRQ_EN_OFS && reg_wdata == 32'h0 |-> ##[1:2] !irq; endproperty
  a_en_off: assert property (p_en_off) else $error("irq high with enables off");
  c_tx: cover property (tx_valid && tx_ready);
  c_drop: cover property ($rose(drop_active));
  c_fc: cover property ($rose(fc_active));
  c_irq: cover property ($fell(irq));
endmodule // epc_monitor

bind epc_top epc_monitor u_mon (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .frm_valid(frm_valid), .tx_ready(tx_ready),
  .tx_valid(tx_valid), .tx_queue(tx_queue), .tx_id(tx_id), .fc_active(fc_active),
  .drop_active(drop_active), .irq(irq));

// >>> dv/epc_egress_model.sv
`timescale 1ns/1ps
module epc_egress_model (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        stall,
  input  wire logic        slow,
  input  wire logic        tx_valid,
  input  wire logic [1:0]  tx_queue,
  input  wire logic [7:0]  tx_id,
  input  wire logic [15:0] tx_len,
  output logic             tx_ready
);
  // ----------------------------------------
  // egress consumer
  // ----------------------------------------
  logic [25:0] seen[$];
  // slow mode accepts every other cycle so the slot must hold
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) tx_ready <= 1'b0;
    else tx_ready <= !stall && !(slow && tx_ready);
  end
  // plain always: the bench pops this queue, so it has two writers
  always @(posedge sys_clk) begin
    if (rstn && tx_valid && tx_ready) seen.push_back({tx_queue, tx_len, tx_id});
  end
endmodule // epc_egress_model

// >>> dv/tb_egress_priority_classifier.sv
`timescale 1ns/1ps
module tb_egress_priority_classifier;
  import epc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam logic [47:0] MA = 48'hA1B2C3D4E5F6;
  localparam logic [11:0] VL = 12'h005;
  localparam logic [31:0] IA = 32'hC0A80A07;
  logic        sys_clk = 1'b0, rstn = 1'b0, reg_we = 1'b0, reg_re = 1'b0, frm_valid = 1'b0, frm_is_ip = 1'b0;
  logic        stall = 1'b0, slow = 1'b0, tx_ready, tx_valid, fc_active, drop_active, irq;
  logic [7:0]  reg_addr = 8'h00, frm_id = 8'h00, tx_id;
  logic [31:0] reg_wdata = 32'h0, frm_dip = 32'h0, frm_sip = 32'h0, reg_rdata;
  logic [15:0] frm_len = 16'h0, tx_len;
  logic [11:0] frm_vlan = 12'h0;
  logic [47:0] frm_dmac = 48'h0, frm_smac = 48'h0;
  logic [1:0]  tx_queue;
  int          err_count = 0, tests_run = 0;
  epc_top DUT (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .frm_valid(frm_valid), .frm_id(frm_id), .frm_len(frm_len),
    .frm_vlan(frm_vlan), .frm_dmac(frm_dmac), .frm_smac(frm_smac), .frm_is_ip(frm_is_ip), .frm_dip(frm_dip),
    .frm_sip(frm_sip), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_queue(tx_queue), .tx_id(tx_id),
    .tx_len(tx_len), .fc_active(fc_active), .drop_active(drop_active), .irq(irq));
  epc_egress_model PM (.sys_clk(sys_clk), .rstn(rstn), .stall(stall), .slow(slow), .tx_valid(tx_valid),
    .tx_queue(tx_queue), .tx_id(tx_id), .tx_len(tx_len), .tx_ready(tx_ready));
  initial forever #2.5 sys_clk = ~sys_clk;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {reg_we, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    {reg_re, reg_addr} <= {1'b1, a};
    @(posedge sys_clk);
    reg_re <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // all descriptor fields change together, so one assignment keeps them paired
  task automatic fr(input logic [7:0] id, input logic [11:0] vl = VL, input logic [47:0] d = 48'h0,
                    input logic [47:0] s = 48'h0, input logic ip = 1'b0, input logic [31:0] a = 32'h0,
                    input logic [15:0] len = 16'h0040);
    @(posedge sys_clk);
    {frm_valid, frm_id, frm_vlan, frm_dmac, frm_smac, frm_is_ip, frm_dip, frm_sip, frm_len}
      <= {1'b1, id, vl, d, s, ip, a, ~a, len};
    @(posedge sys_clk);
    frm_valid <= 1'b0;
  endtask
  task automatic expq(input logic [1:0] q, input logic [7:0] id, input logic [15:0] len = 16'h0040);
    logic [25:0] v;
    for (int i = 0; i < 60 && PM.seen.size() == 0; i++) @(posedge sys_clk);
    if (PM.seen.size() == 0) begin
      err_count++;
      close_out();
    end
    v = PM.seen.pop_front();
    chk(32'(v), 32'({q, len, id}));
  endtask
  task automatic mac(input logic [2:0] pr, input epc_dir_e dr);
    wr(EPC_MAC_BASE + 8'h04, {2'b10, dr, 1'b0, pr, 8'h00, MA[47:32]});
  endtask
  task automatic ipc(input epc_dir_e dr);
    wr(EPC_IP_BASE + 8'h04, {2'b10, dr, 28'h0});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(EPC_THRESH_OFS, 32'h0000E000);
    rd(EPC_CTRL_OFS, 32'h0);
    rd(EPC_IRQ_EN_OFS, 32'h0);
    rd(EPC_STATUS_OFS, 32'h0);
    wr(8'h3C, 32'hFFFFFFFF);
    rd(8'h3C, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_class();
    slow <= 1'b1;
    wr(EPC_MAC_BASE, MA[31:0]);
    wr(EPC_MAC_BASE + 8'h08, {20'h0, VL});
    for (int p = 0; p < 8; p++) begin
      mac(3'(p), EPC_DIR_DST);
      fr(8'(p), VL, MA);
      expq(2'(p >> 1), 8'(p));
    end
    fr(8'h08, VL + 12'h001, MA);
    expq(2'h0, 8'h08);
    fr(8'h09, VL, 48'h0, MA);
    expq(2'h0, 8'h09);
    mac(3'h5, EPC_DIR_SRC);
    fr(8'h0A, VL, 48'h0, MA);
    expq(2'h2, 8'h0A);
    mac(3'h3, EPC_DIR_EITHER);
    fr(8'h0B, VL, 48'h0, MA);
    expq(2'h1, 8'h0B);
    fr(8'h0C, VL, MA);
    expq(2'h1, 8'h0C);
    // the fourth direction code matches nothing
    wr(EPC_MAC_BASE + 8'h04, {2'b10, 2'b11, 1'b0, 3'h7, 8'h00, MA[47:32]});
    fr(8'h0D, VL, MA, MA);
    expq(2'h0, 8'h0D);
    slow <= 1'b0;
    $display("t_class done");
  endtask
  task automatic t_strict();
    stall <= 1'b1;
    repeat (2) @(posedge sys_clk);
    fr(8'h20, VL + 12'h001);
    mac(3'h2, EPC_DIR_DST);
    fr(8'h21, VL, MA);
    mac(3'h6, EPC_DIR_DST);
    fr(8'h22, VL, MA);
    repeat (4) @(posedge sys_clk);
    rd(EPC_STATUS_OFS, 32'h000000A0);
    stall <= 1'b0;
    expq(2'h0, 8'h20);
    expq(2'h3, 8'h22);
    expq(2'h1, 8'h21);
    $display("t_strict done");
  endtask
  task automatic t_ip();
    wr(EPC_IRQ_EN_OFS, 32'h3);
    wr(EPC_IP_BASE, IA);
    ipc(EPC_DIR_DST);
    fr(8'h30, VL, 48'h0, 48'h0, 1'b1, IA);
    repeat (6) @(posedge sys_clk);
    chk(32'(drop_active), 32'h1);
    chk(32'(irq), 32'h1);
    rd(EPC_IRQ_STAT_OFS, 32'h1);
    wr(EPC_IRQ_CLR_OFS, 32'h3);
    rd(EPC_IRQ_STAT_OFS, 32'h0);
    ipc(EPC_DIR_EITHER);
    fr(8'h31, VL, 48'h0, 48'h0, 1'b1, ~IA);
    repeat (6) @(posedge sys_clk);
    chk(32'(PM.seen.size()), 32'h0);
    ipc(EPC_DIR_SRC);
    fr(8'h32, VL, 48'h0, 48'h0, 1'b1, IA);
    expq(2'h0, 8'h32);
    chk(32'(drop_active), 32'h0);
    wr(EPC_IRQ_CLR_OFS, 32'h3);
    repeat (3) @(posedge sys_clk);
    chk(32'(irq), 32'h0);
    $display("t_ip done");
  endtask
  task automatic t_fc();
    wr(EPC_CTRL_OFS, 32'h1);
    wr(EPC_THRESH_OFS, 32'h00000064);
    stall <= 1'b1;
    repeat (2) @(posedge sys_clk);
    // one frame parks in the slot, four fill queue 0, the sixth is tail-dropped
    for (int i = 0; i < 6; i++) fr(8'(8'h40 + i), VL + 12'h001, 48'h0, 48'h0, 1'b0, 32'h0, 16'h003C);
    repeat (6) @(posedge sys_clk);
    chk(32'(fc_active), 32'h1);
    rd(EPC_STATUS_OFS, 32'h00000013);
    rd(EPC_IRQ_STAT_OFS, 32'h3);
    chk(32'(irq), 32'h1);
    stall <= 1'b0;
    for (int i = 0; i < 5; i++) expq(2'h0, 8'(8'h40 + i), 16'h003C);
    repeat (4) @(posedge sys_clk);
    chk(32'(fc_active), 32'h0);
    chk(32'(drop_active), 32'h1);
    wr(EPC_IRQ_EN_OFS, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk(32'(irq), 32'h0);
    wr(EPC_IRQ_CLR_OFS, 32'h3);
    wr(EPC_CTRL_OFS, 32'h0);
    $display("t_fc done");
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_regs();
    t_class();
    t_strict();
    t_ip();
    t_fc();
    close_out();
  end
endmodule // tb_egress_priority_classifier
